// >>> b3m_mode_control_regs.sv
// Our own choice: strobed register access.
`timescale 1ns/1ps
module b3m_mode_control_regs #(
   parameter int DATA_W = b3m_pkg::DATA_W,
   parameter int ADDR_W = b3m_pkg::ADDR_W
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [DATA_W-1:0] rdata,
   input wire b3m_pkg::b3m_fuse_s fuse,
   output b3m_pkg::b3m_ctrl_s ctrl,
   output logic [b3m_pkg::CODE_W-1:0] sleep_code,
   output logic fuses_loaded
);

   if (DATA_W != 8) begin : g_bad_data
      $error("b3m_mode_control_regs: data width must be 8");
   end
   if (ADDR_W < 7) begin : g_bad_addr
      $error("b3m_mode_control_regs: address too narrow for the offsets");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic [7:0] ctrl_to_byte(input b3m_pkg::b3m_ctrl_s c);
      logic [7:0] b;
      b = 8'h00;
      b[b3m_pkg::BIT_RUN_EN] = c.run_enable;
      b[b3m_pkg::BIT_STBY_EN] = c.standby_enable;
      b[b3m_pkg::BIT_SLEEP_EN] = c.sleep_enable;
      b[b3m_pkg::BIT_LOW_PWR] = c.low_power_select;
      b[b3m_pkg::BIT_FPW] = c.forced_pulse_width;
      b[b3m_pkg::BIT_DIS_N] = c.discharge_disable_n;
      return b;
   endfunction

   // Register image to fields; the reset value goes through here too
   function automatic b3m_pkg::b3m_ctrl_s byte_to_ctrl(input logic [7:0] b);
      b3m_pkg::b3m_ctrl_s c;
      c.run_enable = b[b3m_pkg::BIT_RUN_EN];
      c.standby_enable = b[b3m_pkg::BIT_STBY_EN];
      c.sleep_enable = b[b3m_pkg::BIT_SLEEP_EN];
      c.low_power_select = b[b3m_pkg::BIT_LOW_PWR];
      c.forced_pulse_width = b[b3m_pkg::BIT_FPW];
      c.discharge_disable_n = b[b3m_pkg::BIT_DIS_N];
      return c;
   endfunction

   function automatic logic hits(input logic [ADDR_W-1:0] a, input logic [7:0] offs);
      return a == ADDR_W'(offs);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Decode

   logic wr_ctrl;
   logic rd_volt;
   logic rd_ctrl;

   assign wr_ctrl = wr && hits(addr, b3m_pkg::OFFS_MODE_CTRL);
   assign rd_volt = rd && hits(addr, b3m_pkg::OFFS_SLEEP_VOLT);
   assign rd_ctrl = rd && hits(addr, b3m_pkg::OFFS_MODE_CTRL);

   ////////////////////////////////////////////////////////////////////////////
   // Fuse load tracking

   b3m_pkg::b3m_load_e load_state;
   b3m_pkg::b3m_load_e next_load_state;
   logic next_fuses_loaded;

   always_comb begin
      next_load_state = load_state;
      case (load_state)
         b3m_pkg::LD_WAIT: begin
            if (fuse.load) begin
               next_load_state = b3m_pkg::LD_DONE;
            end
         end
         b3m_pkg::LD_DONE: begin
            next_load_state = b3m_pkg::LD_DONE;
         end
         default: begin
            next_load_state = b3m_pkg::LD_WAIT;
         end
      endcase
      next_fuses_loaded = next_load_state == b3m_pkg::LD_DONE;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         load_state <= b3m_pkg::LD_WAIT;
         fuses_loaded <= 1'b0;
      end else begin
         load_state <= next_load_state;
         fuses_loaded <= next_fuses_loaded;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sleep voltage code

   b3m_sleep_code #(
      .CODE_W(b3m_pkg::CODE_W)
   ) u_sleep_code (
      .mclk(mclk),
      .rst(rst),
      .load(fuse.load),
      .load_code(fuse.sleep_code),
      .code(sleep_code)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Mode control register

   b3m_pkg::b3m_ctrl_s next_ctrl;

   always_comb begin
      next_ctrl = ctrl;
      if (wr_ctrl) begin
         next_ctrl.run_enable = wdata[b3m_pkg::BIT_RUN_EN];
         next_ctrl.standby_enable = wdata[b3m_pkg::BIT_STBY_EN];
         next_ctrl.sleep_enable = wdata[b3m_pkg::BIT_SLEEP_EN];
         next_ctrl.low_power_select = wdata[b3m_pkg::BIT_LOW_PWR];
         next_ctrl.forced_pulse_width = wdata[b3m_pkg::BIT_FPW];
         next_ctrl.discharge_disable_n = wdata[b3m_pkg::BIT_DIS_N];
      end
      // Hardware load beats a same-cycle software write on fuse fields
      if (fuse.load) begin
         next_ctrl.run_enable = fuse.run_enable;
         next_ctrl.standby_enable = fuse.run_enable;
         next_ctrl.discharge_disable_n = fuse.discharge_disable_n;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         ctrl <= byte_to_ctrl(b3m_pkg::RESET_MODE_CTRL);
      end else begin
         ctrl <= next_ctrl;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read port

   logic [DATA_W-1:0] next_rdata;
   logic [DATA_W-1:0] volt_image;
   logic [DATA_W-1:0] ctrl_image;

   // Masking here keeps unused bits zero whatever the fields hold
   assign volt_image = DATA_W'({4'h0, sleep_code} & b3m_pkg::VOLT_USED_MASK);
   assign ctrl_image = DATA_W'(ctrl_to_byte(ctrl) & b3m_pkg::CTRL_USED_MASK);

   always_comb begin
      next_rdata = '0;
      if (rd_volt) begin
         next_rdata = volt_image;
      end else if (rd_ctrl) begin
         next_rdata = ctrl_image;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         rdata <= '0;
      end else begin
         rdata <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   logic [ADDR_W-1:0] addr_q;
   logic rd_q;

   always_ff @(posedge mclk) begin
      if (rst) begin
         addr_q <= '0;
         rd_q <= 1'b0;
      end else begin
         addr_q <= addr;
         rd_q <= rd;
      end
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   a_code_fuse_load: assert property (
      fuse.load |=> sleep_code == $past(fuse.sleep_code)
   ) else $error("sleep code not taken from fuses");

   a_code_no_write: assert property (
      (wr && !fuse.load) |=> $stable(sleep_code)
   ) else $error("software write changed sleep code");

   a_run_fuse_load: assert property (
      fuse.load |=> ctrl.run_enable == $past(fuse.run_enable)
   ) else $error("run enable not loaded from fuses");

   a_run_sw_clear: assert property (
      (wr_ctrl && !wdata[b3m_pkg::BIT_RUN_EN] && !fuse.load) |=> !ctrl.run_enable
   ) else $error("software could not clear run enable");

   a_standby_write: assert property (
      (wr_ctrl && !fuse.load) |=> ctrl.standby_enable == $past(wdata[b3m_pkg::BIT_STBY_EN])
   ) else $error("standby enable write lost");

   a_standby_default: assert property (
      fuse.load |=> ctrl.standby_enable == ctrl.run_enable
   ) else $error("standby default differs from run enable");

   a_sleep_write: assert property (
      wr_ctrl |=> ctrl.sleep_enable == $past(wdata[b3m_pkg::BIT_SLEEP_EN])
   ) else $error("sleep enable write lost");

   a_lowpower_write: assert property (
      wr_ctrl |=> ctrl.low_power_select == $past(wdata[b3m_pkg::BIT_LOW_PWR])
   ) else $error("low power select write lost");

   a_fpw_write: assert property (
      wr_ctrl |=> ctrl.forced_pulse_width == $past(wdata[b3m_pkg::BIT_FPW])
   ) else $error("forced pulse width write lost");

   a_discharge_fuse: assert property (
      fuse.load |=> ctrl.discharge_disable_n == $past(fuse.discharge_disable_n)
   ) else $error("discharge control not loaded from fuses");

   a_fuse_field_rw: assert property (
      (fuses_loaded && wr_ctrl && !fuse.load)
         |=> ctrl.discharge_disable_n == $past(wdata[b3m_pkg::BIT_DIS_N])
            && ctrl.run_enable == $past(wdata[b3m_pkg::BIT_RUN_EN])
   ) else $error("fuse-loaded field not writable after load");

   a_loaded_flag: assert property (
      fuse.load |=> fuses_loaded
   ) else $error("load flag not raised");

   a_volt_unused_zero: assert property (
      rd_q && hits(addr_q, b3m_pkg::OFFS_SLEEP_VOLT)
         |-> (rdata & ~DATA_W'(b3m_pkg::VOLT_USED_MASK)) == '0
   ) else $error("unused voltage bits read nonzero");

   a_ctrl_readback: assert property (
      rd_ctrl |=> rdata == DATA_W'(ctrl_to_byte($past(ctrl)))
   ) else $error("control readback wrong");

   a_read_one_cycle: assert property (
      !rd |=> rdata == '0
   ) else $error("read data outside its cycle");

   a_ctrl_quiet: assert property (
      (!wr_ctrl && !fuse.load) |=> $stable(ctrl)
   ) else $error("control changed with no cause");

   ////////////////////////////////////////////////////////////////////////////
   // Checks: reset image, fuse priority, decode edges

   // Reset must win even though every other check is disabled by it
   a_reset_clears: assert property (disable iff (1'b0)
      rst |=> ctrl == byte_to_ctrl(b3m_pkg::RESET_MODE_CTRL)
         && sleep_code == b3m_pkg::RESET_SLEEP_CODE
         && rdata == '0 && !fuses_loaded
   ) else $error("reset left state behind");

   a_run_sw_set: assert property (
      (wr_ctrl && wdata[b3m_pkg::BIT_RUN_EN] && !fuse.load) |=> ctrl.run_enable
   ) else $error("software could not set run enable");

   a_standby_sw_clear: assert property (
      (wr_ctrl && !wdata[b3m_pkg::BIT_STBY_EN] && !fuse.load) |=> !ctrl.standby_enable
   ) else $error("software could not clear standby enable");

   a_standby_fuse_load: assert property (
      fuse.load |=> ctrl.standby_enable == $past(fuse.run_enable)
   ) else $error("standby default not taken from run fuse");

   a_sleep_fuse_keep: assert property (
      (fuse.load && !wr_ctrl) |=> $stable(ctrl.sleep_enable)
   ) else $error("fuse load touched sleep enable");

   a_lowpower_fuse_keep: assert property (
      (fuse.load && !wr_ctrl) |=> $stable(ctrl.low_power_select)
   ) else $error("fuse load touched low power select");

   a_fpw_fuse_keep: assert property (
      (fuse.load && !wr_ctrl) |=> $stable(ctrl.forced_pulse_width)
   ) else $error("fuse load touched forced pulse width");

   a_discharge_write: assert property (
      (wr_ctrl && !fuse.load) |=> ctrl.discharge_disable_n == $past(wdata[b3m_pkg::BIT_DIS_N])
   ) else $error("discharge control write lost");

   a_fuse_beats_write: assert property (
      (fuse.load && wr_ctrl)
         |=> ctrl.run_enable == $past(fuse.run_enable)
            && ctrl.standby_enable == $past(fuse.run_enable)
            && ctrl.discharge_disable_n == $past(fuse.discharge_disable_n)
   ) else $error("software write beat a fuse load");

   a_loaded_sticky: assert property (
      fuses_loaded |=> fuses_loaded
   ) else $error("load flag dropped");

   a_loaded_quiet: assert property (
      (!fuse.load && !fuses_loaded) |=> !fuses_loaded
   ) else $error("load flag raised with no load");

   a_state_legal: assert property (
      load_state == b3m_pkg::LD_WAIT || load_state == b3m_pkg::LD_DONE
   ) else $error("load tracker in an unused state");

   a_code_stable_idle: assert property (
      !fuse.load |=> $stable(sleep_code)
   ) else $error("sleep code moved with no fuse load");

   a_code_reload: assert property (
      (fuses_loaded && fuse.load) |=> sleep_code == $past(fuse.sleep_code)
   ) else $error("sleep code not reloaded from fuses");

   a_volt_readback: assert property (
      rd_volt |=> rdata == DATA_W'({4'h0, $past(sleep_code)})
   ) else $error("voltage readback wrong");

   a_ctrl_unused_zero: assert property (
      rd_q && hits(addr_q, b3m_pkg::OFFS_MODE_CTRL)
         |-> (rdata & ~DATA_W'(b3m_pkg::CTRL_USED_MASK)) == '0
   ) else $error("unused control bits read nonzero");

   a_unmapped_read: assert property (
      (rd && !rd_volt && !rd_ctrl) |=> rdata == '0
   ) else $error("unmapped read returned data");

   a_ctrl_write_image: assert property (
      (wr_ctrl && !fuse.load) |=> ctrl == byte_to_ctrl($past(wdata))
   ) else $error("control write image wrong");

   a_write_only_ctrl: assert property (
      (wr && !wr_ctrl && !fuse.load) |=> $stable(ctrl)
   ) else $error("stray write changed control");

   a_read_no_side: assert property (
      (rd && !wr && !fuse.load) |=> $stable(ctrl) && $stable(sleep_code)
   ) else $error("read disturbed register state");

endmodule // b3m_mode_control_regs

// >>> b3m_mode_control_regs_tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
   $display("[ERR] %s expected %h seen %h", nm, e, g); n_fail++; end end

module b3m_mode_control_regs_tb_top;
   typedef struct packed {
      logic [7:0] wd;
      logic [7:0] rb;
      logic [5:0] ct;
   } b3m_row_s;

   logic mclk;
   logic rst;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic wr;
   logic rd;
   logic [7:0] rdata;
   b3m_pkg::b3m_fuse_s fuse;
   b3m_pkg::b3m_ctrl_s ctrl;
   logic [3:0] sleep_code;
   logic fuses_loaded;
   int n_fail;
   int n_compared;

   // Written byte, readback, packed ctrl
   b3m_row_s rows [10] = '{'{8'hcf, 8'hcf, 6'h3f}, '{8'h30, 8'h00, 6'h00}, '{8'h01, 8'h01, 6'h01},
      '{8'h02, 8'h02, 6'h02}, '{8'h04, 8'h04, 6'h04}, '{8'h08, 8'h08, 6'h08}, '{8'h40, 8'h40, 6'h10},
      '{8'h80, 8'h80, 6'h20}, '{8'hff, 8'hcf, 6'h3f}, '{8'h00, 8'h00, 6'h00}};
   // Load, run, discharge, code: both code extremes
   logic [6:0] loads [3] = '{7'h7f, 7'h40, 7'h75};

   b3m_mode_control_regs u_dut (
      .mclk(mclk),
      .rst(rst),
      .addr(addr),
      .wdata(wdata),
      .wr(wr),
      .rd(rd),
      .rdata(rdata),
      .fuse(fuse),
      .ctrl(ctrl),
      .sleep_code(sleep_code),
      .fuses_loaded(fuses_loaded)
   );

   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   ////////////////////////////////////////////////////////////////////////////
   // One call per cycle, so no signal is assigned twice in a time step
   task automatic cyc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d,
                      input logic [6:0] f);
      @(posedge mclk);
      wr <= w;
      rd <= r;
      addr <= a;
      wdata <= d;
      fuse <= f;
   endtask

   // Checks land at the falling edge, clear of update races
   task automatic settle;
      cyc(1'b0, 1'b0, 8'h00, 8'h00, 7'h00);
      @(negedge mclk);
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      cyc(1'b1, 1'b0, a, d, 7'h00);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string nm);
      cyc(1'b0, 1'b1, a, 8'h00, 7'h00);
      settle();
      `CHK(nm, e, rdata)
   endtask

   task automatic do_reset;
      cyc(1'b0, 1'b0, 8'h00, 8'h00, 7'h00);
      rst <= 1'b1;
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      @(negedge mclk);
   endtask

   task automatic chk_zero;
      `CHK("rdata", 8'h00, rdata)
      `CHK("ctrl", 6'h00, ctrl)
      `CHK("sleep_code", 4'h0, sleep_code)
      `CHK("fuses_loaded", 1'b0, fuses_loaded)
   endtask

   task automatic tally_and_finish;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      #1000000;
      n_fail++;
      tally_and_finish();
   end

   initial begin
      rst = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
      fuse = '0;
      n_fail = 0;
      n_compared = 0;
      do_reset();
      chk_zero();
      foreach (rows[i]) begin
         wr_reg(8'h41, rows[i].wd);
         rd_chk(8'h41, rows[i].rb, "ctrl readback");
         `CHK("ctrl", rows[i].ct, ctrl)
      end
      foreach (loads[i]) begin
         cyc(1'b0, 1'b0, 8'h00, 8'h00, loads[i]);
         settle();
         `CHK("sleep_code", loads[i][3:0], sleep_code)
         `CHK("run", loads[i][5], ctrl.run_enable)
         `CHK("standby", loads[i][5], ctrl.standby_enable)
         `CHK("discharge_n", loads[i][4], ctrl.discharge_disable_n)
         `CHK("fuses_loaded", 1'b1, fuses_loaded)
         rd_chk(8'h40, {4'h0, loads[i][3:0]}, "code readback");
      end
      wr_reg(8'h40, 8'hfa);
      rd_chk(8'h40, 8'h05, "code after write");
      `CHK("sleep_code", 4'h5, sleep_code)
      wr_reg(8'h41, 8'h82);
      rd_chk(8'h41, 8'h82, "run cleared");
      `CHK("run", 1'b0, ctrl.run_enable)
      // Back-to-back: unmapped write, unmapped read, mapped read
      wr_reg(8'h42, 8'hff);
      cyc(1'b0, 1'b1, 8'h42, 8'h00, 7'h00);
      cyc(1'b0, 1'b1, 8'h41, 8'h00, 7'h00);
      @(negedge mclk);
      `CHK("unmapped read", 8'h00, rdata)
      settle();
      `CHK("ctrl kept", 8'h82, rdata)
      settle();
      `CHK("rdata one cycle", 8'h00, rdata)
      // Fuse and write together: fuse owns run, standby, discharge
      cyc(1'b1, 1'b0, 8'h41, 8'hff, 7'h43);
      settle();
      `CHK("ctrl collide", 6'h1c, ctrl)
      `CHK("sleep_code", 4'h3, sleep_code)
      do_reset();
      chk_zero();
      tally_and_finish();
   end
endmodule // b3m_mode_control_regs_tb_top

// >>> b3m_pkg.sv
// What this block does
// - Four-bit sleep voltage code in bits 3..0, filled from fuses, codes 0000 to 1111.
// - Sleep voltage code is read-only to software; writes never change it.
// - Bit 0 run enable, fuse-loaded; zero disables, one enables; clearing turns off.
// - Bit 1 standby enable; one keeps regulator on in standby, software may clear.
// - Standby enable default follows the fuse-derived run enable.
// - Bit 2 sleep enable, software-writable; one keeps regulator on in sleep.
// - Bit 3 selects low-power operation during standby and sleep.
// - Bit 6 forces continuous-conduction fixed pulse width regardless of load.
// - Bit 7 active low; zero connects discharge resistor while regulator is off.
// - Fuse-loaded fields load at start-up, then software reads and writes them.
package b3m_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int CODE_W = 4;

   ////////////////////////////////////////////////////////////////////////////
   localparam logic [7:0] OFFS_SLEEP_VOLT = 8'h40;
   localparam logic [7:0] OFFS_MODE_CTRL = 8'h41;

   localparam int BIT_RUN_EN = 0;
   localparam int BIT_STBY_EN = 1;
   localparam int BIT_SLEEP_EN = 2;
   localparam int BIT_LOW_PWR = 3;
   localparam int BIT_FPW = 6;
   localparam int BIT_DIS_N = 7;

   localparam logic [7:0] VOLT_USED_MASK = 8'h0f;
   localparam logic [7:0] CTRL_USED_MASK = 8'hcf;

   localparam logic [3:0] RESET_SLEEP_CODE = 4'h0;
   localparam logic [7:0] RESET_MODE_CTRL = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic discharge_disable_n;
      logic forced_pulse_width;
      logic low_power_select;
      logic sleep_enable;
      logic standby_enable;
      logic run_enable;
   } b3m_ctrl_s;

   typedef struct packed {
      logic load;
      logic run_enable;
      logic discharge_disable_n;
      logic [3:0] sleep_code;
   } b3m_fuse_s;

   // Gray path: waiting -> loaded
   typedef enum logic [1:0] {
      LD_WAIT = 2'b00,
      LD_DONE = 2'b01
   } b3m_load_e;

endpackage

// >>> b3m_sleep_code.sv
`timescale 1ns/1ps
module b3m_sleep_code #(
   parameter int CODE_W = b3m_pkg::CODE_W
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic load,
   input wire logic [CODE_W-1:0] load_code,
   output logic [CODE_W-1:0] code
);

   if (CODE_W != 4) begin : g_bad_width
      $error("b3m_sleep_code: code width must be 4");
   end

   logic [CODE_W-1:0] next_code;

   // No write path at all: the regulator has no voltage scaling
   always_comb begin
      next_code = code;
      if (load) begin
         next_code = load_code;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         code <= CODE_W'(b3m_pkg::RESET_SLEEP_CODE);
      end else begin
         code <= next_code;
      end
   end

endmodule // b3m_sleep_code
